// *** rtl/paged_serial_register_access.sv ***
`timescale 1ns/1ps
module paged_serial_register_access #(
    parameter int unsigned PAGES     = paged_reg_pkg::PAGE_COUNT,
    parameter int unsigned PAGE_REGS = paged_reg_pkg::REGS_PER_PAGE
) (
    input  logic                             core_clk,
    input  logic                             rst_n,
    input  logic                             protocolSelectPin,
    input  logic                             strapOrChipSelectPinN,
    input  logic                             strapOrSerialClockPin,
    input  logic                             mosi,
    output logic                             miso,
    output logic                             misoOe,
    input  logic                             scl,
    input  logic                             sdaIn,
    output logic                             sdaOut,
    output logic                             sdaOe,
    output logic [paged_reg_pkg::DATA_W-1:0] activePage
);
    import paged_reg_pkg::*;

    // -------------------------------------------------------------------
    // elaboration check
    // -------------------------------------------------------------------
    // the page bit and 7-bit address only serve this exact geometry
    if (PAGES != PAGE_COUNT || PAGE_REGS != (1 << ADDR_W)) begin : g_chk
        $error("unsupported page geometry");
    end

    // -------------------------------------------------------------------
    // storage
    // -------------------------------------------------------------------
    logic [DATA_W-1:0] regMem [PAGES*PAGE_REGS];  // both pages, core domain

    // core domain state
    typedef struct packed {
        logic [1:0]        modeSync;   // protocol pin synchroniser
        logic [1:0]        strap0Sync; // strap bit 0 synchroniser
        logic [1:0]        strap1Sync; // strap bit 1 synchroniser
        logic [2:0]        sclSync;    // two stages plus history
        logic [2:0]        sdaSync;    // two stages plus history
        logic [2:0]        wrTglSync;  // spi write event, plus history
        logic              linkRst;    // clears link write event
        logic [DATA_W-1:0] pageReg;    // page_selector contents
        i2c_state_t        iState;     // i2c sequencer
        logic [3:0]        bitCnt;     // bits done in current byte
        logic [7:0]        shifter;    // i2c byte shifter
        logic [6:0]        regPtr;     // i2c register pointer
        logic              haveAddr;   // register address received
        logic              readMode;   // address byte asked for read
        logic              genCall;    // general call in progress
        logic              ackSeen;    // master acked our byte
        logic              sdaOe;      // pull SDA low
        logic              sdaOut;     // level when driving, always low
    } core_t;

    // link domain state, cleared while chip select is high
    typedef struct packed {
        logic [3:0] cnt;      // bit position in byte
        logic       cmdDone;  // command byte taken
        logic       isRead;   // direction of this frame
        logic [6:0] addr;     // current register address
        logic [7:0] rxShift;  // bits from MOSI
        logic [7:0] txShift;  // bits toward MISO
    } spi_t;

    core_t       cur_reg, cur_next;  // core state
    spi_t        spi_reg, spi_next;  // link state
    logic        spiWe;              // link: data byte complete
    logic        wrTgl_reg;          // link: toggles per written byte
    logic [6:0]  wrAddr_reg;         // link: held write address
    logic [7:0]  wrData_reg;         // link: held write data
    logic        memWe;              // core memory write strobe
    logic [6:0]  memAddr;            // core memory write address
    logic [7:0]  memData;            // core memory write data

    // -------------------------------------------------------------------
    // shared decoding
    // -------------------------------------------------------------------
    // address zero is the same selector on every page
    function automatic logic isPageSel(input logic [6:0] a);
        return a == PAGE_SEL_ADDR;
    endfunction

    // read view of the register space through the active page
    function automatic logic [7:0] readReg(input logic [6:0] a);
        if (isPageSel(a)) begin
            return cur_reg.pageReg;
        end
        return regMem[{cur_reg.pageReg[0], a}];
    endfunction

    // -------------------------------------------------------------------
    // link domain: SPI shifter on the serial clock
    // -------------------------------------------------------------------
    // samples MOSI on falling edges; reloads MISO data at the command byte end and at each read byte end
    always_comb begin
        spi_next         = spi_reg;
        spiWe            = 1'b0;
        spi_next.rxShift = {spi_reg.rxShift[6:0], mosi};
        spi_next.txShift = {spi_reg.txShift[6:0], 1'b0};
        spi_next.cnt     = spi_reg.cnt + BIT_ONE;
        if (spi_reg.cnt == BIT_LAST) begin
            spi_next.cnt = BIT_ZERO;
            if (!spi_reg.cmdDone) begin
                // first byte of a frame is always the command
                spi_next.cmdDone = 1'b1;
                spi_next.addr    = spi_reg.rxShift[6:0];
                spi_next.isRead  = (mosi == RW_READ);
                spi_next.txShift = readReg(spi_reg.rxShift[6:0]);
            end else begin
                // further bytes walk up the page
                spi_next.addr = spi_reg.addr + 7'h01;
                if (spi_reg.isRead) begin
                    spi_next.txShift = readReg(spi_reg.addr + 7'h01);
                end else begin
                    spiWe = 1'b1;
                end
            end
        end
    end

    // chip select high clears the frame without needing a clock edge
    always_ff @(negedge strapOrSerialClockPin
                or posedge strapOrChipSelectPinN) begin
        if (strapOrChipSelectPinN) begin
            spi_reg <= '0;
        end else begin
            spi_reg <= spi_next;
        end
    end

    // write event kept out of the frame reset so a last byte is not lost
    always_ff @(negedge strapOrSerialClockPin or posedge cur_reg.linkRst) begin
        if (cur_reg.linkRst) begin
            wrTgl_reg  <= 1'b0;
            wrAddr_reg <= PAGE_SEL_ADDR;
            wrData_reg <= PAGE_RESET;
        end else if (spiWe) begin
            wrTgl_reg  <= ~wrTgl_reg;
            wrAddr_reg <= spi_reg.addr;
            wrData_reg <= {spi_reg.rxShift[6:0], mosi};
        end
    end

    // MISO launched on rising edges, driven only in read frames
    always_ff @(posedge strapOrSerialClockPin
                or posedge strapOrChipSelectPinN) begin
        if (strapOrChipSelectPinN) begin
            miso   <= 1'b0;
            misoOe <= 1'b0;
        end else begin
            miso   <= spi_reg.txShift[7];
            misoOe <= spi_reg.cmdDone && spi_reg.isRead;
        end
    end

    // -------------------------------------------------------------------
    // core domain: synchronisers, i2c slave, register writes
    // -------------------------------------------------------------------
    // the i2c lines are oversampled; 20 MHz is ample for fast mode
    always_comb begin
        logic       sclRise;
        logic       sclFall;
        logic       startCond;
        logic       stopCond;
        logic       isI2c;
        logic       spiEvt;
        logic [6:0] ownAddr;
        logic [7:0] rdByte;
        cur_next = cur_reg;
        memWe    = 1'b0;
        memAddr  = PAGE_SEL_ADDR;
        memData  = PAGE_RESET;

        // two stages per pin; history stage feeds edge detection only
        cur_next.modeSync   = {cur_reg.modeSync[0], protocolSelectPin};
        cur_next.strap0Sync = {cur_reg.strap0Sync[0], strapOrChipSelectPinN};
        cur_next.strap1Sync = {cur_reg.strap1Sync[0], strapOrSerialClockPin};
        cur_next.sclSync    = {cur_reg.sclSync[1:0], scl};
        cur_next.sdaSync    = {cur_reg.sdaSync[1:0], sdaIn};
        cur_next.wrTglSync  = {cur_reg.wrTglSync[1:0], wrTgl_reg};
        cur_next.linkRst    = 1'b0;
        cur_next.sdaOut     = 1'b0;

        isI2c     = (cur_reg.modeSync[1] != MODE_SPI);
        sclRise   = cur_reg.sclSync[1] && !cur_reg.sclSync[2];
        sclFall   = !cur_reg.sclSync[1] && cur_reg.sclSync[2];
        startCond = cur_reg.sclSync[1] && cur_reg.sclSync[2]
                    && !cur_reg.sdaSync[1] && cur_reg.sdaSync[2];
        stopCond  = cur_reg.sclSync[1] && cur_reg.sclSync[2]
                    && cur_reg.sdaSync[1] && !cur_reg.sdaSync[2];
        ownAddr   = {I2C_ADDR_FIXED, cur_reg.strap1Sync[1],
                     cur_reg.strap0Sync[1]};
        spiEvt    = cur_reg.wrTglSync[1] != cur_reg.wrTglSync[2];
        rdByte    = readReg(cur_reg.regPtr);

        // spi write bytes: held word is stable long before the event
        if (spiEvt && !isI2c) begin
            memWe   = 1'b1;
            memAddr = wrAddr_reg;
            memData = wrData_reg;
        end

        if (!isI2c) begin
            // port idle in spi mode, SDA released
            cur_next.iState = I2C_IDLE;
            cur_next.sdaOe  = 1'b0;
        end else if (startCond) begin
            // new or repeated start; register pointer survives it
            cur_next.iState = I2C_DEVADDR;
            cur_next.bitCnt = BIT_ZERO;
            cur_next.sdaOe  = 1'b0;
        end else if (stopCond) begin
            cur_next.iState = I2C_IDLE;
            cur_next.sdaOe  = 1'b0;
        end else begin
            case (cur_reg.iState)
                I2C_DEVADDR, I2C_RX: begin
                    if (sclRise) begin
                        cur_next.shifter = {cur_reg.shifter[6:0],
                                            cur_reg.sdaSync[1]};
                        cur_next.bitCnt  = cur_reg.bitCnt + BIT_ONE;
                    end else if (sclFall && cur_reg.bitCnt == BIT_ACK) begin
                        if (cur_reg.iState == I2C_DEVADDR) begin
                            if (cur_reg.shifter[7:1] == ownAddr
                                || (cur_reg.shifter[7:1] == GEN_CALL_ADDR
                                    && cur_reg.shifter[0] != RW_READ)) begin
                                cur_next.iState   = I2C_ACKOUT;
                                cur_next.sdaOe    = 1'b1;
                                cur_next.readMode = cur_reg.shifter[0];
                                cur_next.genCall  = cur_reg.shifter[7:1]
                                                    != ownAddr;
                                cur_next.haveAddr = 1'b0;
                            end else begin
                                cur_next.iState = I2C_WAIT;
                            end
                        end else begin
                            cur_next.iState = I2C_ACKOUT;
                            cur_next.sdaOe  = 1'b1;
                            if (cur_reg.genCall) begin
                                // general call bytes are acked, not stored
                                cur_next.genCall = 1'b1;
                            end else if (!cur_reg.haveAddr) begin
                                cur_next.regPtr   = cur_reg.shifter[6:0];
                                cur_next.haveAddr = 1'b1;
                            end else begin
                                memWe           = 1'b1;
                                memAddr         = cur_reg.regPtr;
                                memData         = cur_reg.shifter;
                                cur_next.regPtr = cur_reg.regPtr
                                                  + 7'h01;
                            end
                        end
                    end
                end
                I2C_ACKOUT: begin
                    // release at the end of the ninth clock
                    if (sclFall) begin
                        cur_next.bitCnt = BIT_ZERO;
                        if (cur_reg.readMode == RW_READ) begin
                            cur_next.iState  = I2C_TX;
                            cur_next.shifter = {rdByte[6:0], 1'b0};
                            cur_next.sdaOe   = !rdByte[7];
                            cur_next.bitCnt  = BIT_ONE;
                            cur_next.regPtr  = cur_reg.regPtr + 7'h01;
                        end else begin
                            cur_next.iState = I2C_RX;
                            cur_next.sdaOe  = 1'b0;
                        end
                    end
                end
                I2C_TX: begin
                    // next bit placed while SCL is low
                    if (sclFall) begin
                        if (cur_reg.bitCnt == BIT_ACK) begin
                            cur_next.iState = I2C_ACKIN;
                            cur_next.sdaOe  = 1'b0;
                        end else begin
                            cur_next.sdaOe   = !cur_reg.shifter[7];
                            cur_next.shifter = {cur_reg.shifter[6:0], 1'b0};
                            cur_next.bitCnt  = cur_reg.bitCnt + BIT_ONE;
                        end
                    end
                end
                I2C_ACKIN: begin
                    if (sclRise) begin
                        cur_next.ackSeen = !cur_reg.sdaSync[1];
                    end else if (sclFall) begin
                        if (cur_reg.ackSeen) begin
                            cur_next.iState  = I2C_TX;
                            cur_next.shifter = {rdByte[6:0], 1'b0};
                            cur_next.sdaOe   = !rdByte[7];
                            cur_next.bitCnt  = BIT_ONE;
                            cur_next.regPtr  = cur_reg.regPtr + 7'h01;
                        end else begin
                            cur_next.iState = I2C_WAIT;
                            cur_next.sdaOe  = 1'b0;
                        end
                    end
                end
                I2C_WAIT: begin
                    cur_next.sdaOe = 1'b0;
                end
                default: begin
                    cur_next.sdaOe = 1'b0; // idle, only a START wakes us
                end
            endcase
        end

        // page selector write; only bit 0 is kept, two pages exist
        if (memWe && isPageSel(memAddr)) begin
            cur_next.pageReg = {PAGE_SEL_MASK, memData[0]};
        end
    end

    // state register; reset holds the link write event cleared
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            cur_reg         <= '0;
            cur_reg.pageReg <= PAGE_RESET;
            cur_reg.iState  <= I2C_IDLE;
            // idle bus lines are high; avoids a false edge after reset
            cur_reg.sclSync <= '1;
            cur_reg.sdaSync <= '1;
            cur_reg.linkRst <= 1'b1;
        end else begin
            cur_reg <= cur_next;
        end
    end

    // register storage write port; selector lives in the state register
    always_ff @(posedge core_clk) begin
        if (memWe && !isPageSel(memAddr)) begin
            regMem[{cur_reg.pageReg[0], memAddr}] <= memData;
        end
    end

    // -------------------------------------------------------------------
    // outputs
    // -------------------------------------------------------------------
    assign sdaOe      = cur_reg.sdaOe;
    assign sdaOut     = cur_reg.sdaOut;
    assign activePage = cur_reg.pageReg;

endmodule // paged_serial_register_access

// *** rtl/paged_reg_pkg.sv ***
//------------------------------------------------------------------------
// Functional notes
// - SPI command: 7-bit address MSB first, direction
// - SPI direction zero: next byte is written
// - SPI direction one: value shifted out second byte
// - pages of 128 registers, address zero shared
// - address zero write picks page for later accesses
// - two pages only, page zero after reset
// - 0x01 selects second page, 0x00 first
// - SPI continuous write fills following registers
// - SPI continuous read streams following registers
// - chip select high ends frame and transfer
// - I2C 7-bit slave, standard and fast rates
// - I2C address 00110 plus two strap pins
// - device is slave only, never clocks
// - SDA only pulled low or released
// - detect START, STOP and repeated START
// - acknowledge own address and written bytes
// - acknowledge general call address 00H too
// - I2C write burst stores to next register
// - I2C read continues while master acknowledges
// - protocol pin high SPI, low I2C, static
// - SPI mode 0/1: launch rising, sample falling
// - first byte command, second data if write
//------------------------------------------------------------------------
package paged_reg_pkg;

    // -------------------------------------------------------------------
    // sizes of the register space
    // -------------------------------------------------------------------
    localparam int unsigned DATA_W        = 8;    // register width
    localparam int unsigned ADDR_W        = 7;    // address within a page
    localparam int unsigned PAGE_COUNT    = 2;    // implemented pages
    localparam int unsigned REGS_PER_PAGE = 128;  // registers per page

    // -------------------------------------------------------------------
    // register map and reset values
    // -------------------------------------------------------------------
    localparam logic [6:0] PAGE_SEL_ADDR = 7'h00;  // page_selector offset
    localparam logic [7:0] PAGE_RESET    = 8'h00;  // page zero after reset
    localparam logic [6:0] PAGE_SEL_MASK = 7'h00;  // upper selector bits

    // -------------------------------------------------------------------
    // serial protocol constants
    // -------------------------------------------------------------------
    localparam logic       MODE_SPI       = 1'b1;   // protocol pin level
    localparam logic       RW_READ        = 1'b1;   // direction bit: read
    localparam logic [4:0] I2C_ADDR_FIXED = 5'h06;  // upper bits 00110
    localparam logic [6:0] GEN_CALL_ADDR  = 7'h00;  // general call
    localparam logic [3:0] BIT_LAST       = 4'h7;   // last bit index
    localparam logic [3:0] BIT_ACK        = 4'h8;   // eight bits done
    localparam logic [3:0] BIT_ONE        = 4'h1;   // after first bit
    localparam logic [3:0] BIT_ZERO       = 4'h0;   // byte start

    // i2c slave sequencing
    typedef enum logic [2:0] {
        I2C_IDLE,     // bus free or not selected
        I2C_DEVADDR,  // receiving address byte
        I2C_RX,       // receiving register address or data
        I2C_ACKOUT,   // we hold SDA low in the ninth clock
        I2C_TX,       // we send a register value
        I2C_ACKIN,    // master acknowledge slot
        I2C_WAIT      // released, waiting for START or STOP
    } i2c_state_t;

endpackage

// *** tb/paged_serial_register_access_chk.sv ***
`timescale 1ns/1ps
module paged_serial_register_access_chk (
    input wire logic                             core_clk,
    input wire logic                             rst_n,
    input wire logic                             protocolSelectPin,
    input wire logic                             strapOrChipSelectPinN,
    input wire logic                             scl,
    input wire logic                             misoOe,
    input wire logic                             sdaOut,
    input wire logic                             sdaOe,
    input wire logic [paged_reg_pkg::DATA_W-1:0] activePage
);
    import paged_reg_pkg::*;
    // ----------------------------------------------------------------
    // port checks, all sampled on the core clock
    // ----------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // an acknowledge low must outlast the synchroniser delay
    sequence ackHold;
        sdaOe [*3];
    endsequence
    sequence inFrame;
        !strapOrChipSelectPinN;
    endsequence
    chk_page_one_bit:
        assert property (activePage[DATA_W-1:1] == 7'h00)
        else $error("page selector beyond two pages");
    chk_sda_open_drain:
        assert property (sdaOut == 1'b0)
        else $error("sda data not low");
    chk_miso_frame_end:
        assert property (strapOrChipSelectPinN |-> !misoOe)
        else $error("miso driven outside a frame");
    chk_miso_in_frame:
        assert property ($rose(misoOe) |-> inFrame)
        else $error("miso enabled without chip select");
    chk_spi_sda_quiet:
        assert property (protocolSelectPin && $past(protocolSelectPin, 3)
                         |-> !sdaOe)
        else $error("sda pulled in serial peripheral mode");
    chk_sda_scl_low:
        assert property ($changed(sdaOe) |-> !scl)
        else $error("sda moved while scl high");
    chk_ack_hold:
        assert property ($rose(sdaOe) |-> ackHold)
        else $error("sda low too short");
    chk_sda_release:
        assert property (sdaOe |-> ##[1:300] !sdaOe)
        else $error("sda held low too long");
endmodule // paged_serial_register_access_chk

bind paged_serial_register_access paged_serial_register_access_chk u_chk (
    .core_clk, .rst_n, .protocolSelectPin, .strapOrChipSelectPinN, .scl,
    .misoOe, .sdaOut, .sdaOe, .activePage);

// *** tb/host_master.sv ***
`timescale 1ns/1ps
// --------------------------------------------------------------------
// host side: serial peripheral and two-wire master, task driven
// --------------------------------------------------------------------
module host_master (
    output logic      csN,
    output logic      sclk,
    output logic      mosi,
    output logic      scl,
    output logic      sdaLow,
    input  wire logic miso,
    input  wire logic sda
);
    int          spiHalf = 16;  // link half period; widen for bursts
    localparam int Q     = 250; // quarter of a two-wire bit, ns
    initial begin
        csN = 1'b1;
        sclk = 1'b0;
        mosi = 1'b0;
        scl = 1'b1;
        sdaLow = 1'b0;
    end
    // link clock stands still between frames
    task automatic spiOpen();
        #7;
        csN = 1'b0;
        #(spiHalf);
    endtask
    task automatic spiClose();
        #(spiHalf);
        csN = 1'b1;
        mosi = ~mosi; // released line must not look held
    endtask
    // launch on rising, device samples on falling
    task automatic spiByte(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            sclk = 1'b1;
            mosi = tx[i];
            #(spiHalf);
            sclk = 1'b0;
            rx[i] = miso;
            #(spiHalf);
        end
    endtask
    // sda only pulled low or let go; data moves while scl low
    task automatic i2cBit(input logic b, output logic r);
        sdaLow = ~b;
        #Q;
        scl = 1'b1;
        #Q;
        r = sda;
        #Q;
        scl = 1'b0;
        #Q;
    endtask
    task automatic i2cStart();
        sdaLow = 1'b0;
        #Q;
        scl = 1'b1;
        #Q;
        sdaLow = 1'b1;
        #Q;
        scl = 1'b0;
        #Q;
    endtask
    task automatic i2cStop();
        sdaLow = 1'b1;
        #Q;
        scl = 1'b1;
        #Q;
        sdaLow = 1'b0;
        #Q;
    endtask
    // eight bits then the acknowledge slot
    task automatic i2cXfer(input logic [8:0] tx, output logic [8:0] rx);
        for (int i = 8; i >= 0; i--) i2cBit(tx[i], rx[i]);
    endtask
endmodule // host_master

// *** tb/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
    import paged_reg_pkg::*;
    // ----------------------------------------------------------------
    // clock, reset, pins
    // ----------------------------------------------------------------
    logic core_clk          = 1'b0;
    logic rst_n             = 1'b0;
    logic protocolSelectPin = 1'b1;
    int   error_cnt         = 0;
    int   total_checks      = 0;
    wire logic strapOrChipSelectPinN, strapOrSerialClockPin, mosi, scl;
    wire logic sdaLow, miso, misoOe, sdaOut, sdaOe;
    wire logic [DATA_W-1:0] activePage;
    wire logic sda = (sdaLow || sdaOe === 1'b1) ? 1'b0 : 1'b1; // pull-up
    // straps sit at idle levels: select high, link clock low
    localparam logic [6:0] devAddr = {5'h06, 1'b0, 1'b1};
    always #25 core_clk = ~core_clk;
    paged_serial_register_access u_paged_serial_register_access (
        .core_clk, .rst_n, .protocolSelectPin, .strapOrChipSelectPinN,
        .strapOrSerialClockPin, .mosi, .miso, .misoOe, .scl, .sdaIn(sda),
        .sdaOut, .sdaOe, .activePage);
    host_master u_host_master (.csN(strapOrChipSelectPinN),
        .sclk(strapOrSerialClockPin), .mosi, .scl, .sdaLow, .miso, .sda);
    task automatic check(input string what, input logic [23:0] exp,
                         input logic [23:0] got);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic doReset(input logic mode);
        @(negedge core_clk);
        protocolSelectPin = mode;
        rst_n = 1'b0;
        repeat (12) @(negedge core_clk);
        rst_n = 1'b1;
        repeat (3) @(negedge core_clk);
    endtask
    // one frame: command then n data bytes; core write lands later
    task automatic spiRun(input logic [7:0] cmd, input logic [23:0] d,
                          input int n, output logic [23:0] q);
        logic [7:0] r;
        u_host_master.spiOpen();
        u_host_master.spiByte(cmd, r);
        for (int i = 0; i < n; i++) begin
            u_host_master.spiByte(d[23-8*i -: 8], r);
            q[23-8*i -: 8] = r;
        end
        u_host_master.spiClose();
        repeat (125) @(negedge core_clk);
    endtask
    task automatic testSpi();
        logic [23:0] q;
        check("pageReset", 24'h0, {16'h0, activePage});
        spiRun({7'h00, 1'b0}, 24'h010000, 1, q);
        check("pageOne", 24'h01, {16'h0, activePage});
        spiRun({7'h00, 1'b1}, 24'h0, 1, q);
        check("pageReadBack", 24'h01, {16'h0, q[23:16]});
        u_host_master.spiHalf = 24;
        spiRun({7'h05, 1'b0}, 24'h5c5d5e, 3, q);
        spiRun({7'h00, 1'b0}, 24'h0, 1, q);
        check("pageZero", 24'h0, {16'h0, activePage});
        spiRun({7'h05, 1'b0}, 24'ha0a1a2, 3, q);
        u_host_master.spiHalf = 16;
        spiRun({7'h05, 1'b1}, 24'h0, 3, q);
        check("burstRead", 24'ha0a1a2, q);
        spiRun({7'h00, 1'b0}, 24'h010000, 1, q);
        spiRun({7'h05, 1'b1}, 24'h0, 3, q);
        check("pageOneRegs", 24'h5c5d5e, q);
    endtask
    task automatic testI2c();
        logic [8:0] r;
        doReset(1'b0);
        u_host_master.i2cStart();
        u_host_master.i2cXfer({devAddr, 1'b0, 1'b1}, r);
        check("addrAck", 24'h0, {23'h0, r[0]});
        u_host_master.i2cXfer({8'h06, 1'b1}, r);
        u_host_master.i2cXfer({8'h33, 1'b1}, r);
        u_host_master.i2cXfer({8'h44, 1'b1}, r);
        check("dataAck", 24'h0, {23'h0, r[0]});
        u_host_master.i2cStop();
        u_host_master.i2cStart();
        u_host_master.i2cXfer({devAddr, 1'b0, 1'b1}, r);
        u_host_master.i2cXfer({8'h06, 1'b1}, r);
        u_host_master.i2cStart();
        u_host_master.i2cXfer({devAddr, 1'b1, 1'b1}, r);
        u_host_master.i2cXfer({8'hff, 1'b0}, r);
        check("readFirst", 24'h33, {16'h0, r[8:1]});
        u_host_master.i2cXfer({8'hff, 1'b1}, r);
        check("readNext", 24'h44, {16'h0, r[8:1]});
        check("nackRelease", 24'h0, {23'h0, sdaOe});
        u_host_master.i2cStop();
        u_host_master.i2cStart();
        u_host_master.i2cXfer({devAddr ^ 7'h01, 1'b0, 1'b1}, r);
        check("foreignNack", 24'h1, {23'h0, r[0]});
        u_host_master.i2cStop();
        u_host_master.i2cStart();
        u_host_master.i2cXfer({8'h00, 1'b1}, r);
        check("genCallAck", 24'h0, {23'h0, r[0]});
        u_host_master.i2cStop();
    endtask
    task automatic summarize();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // watchdog: whole run needs well under 300 us
    initial begin
        #500_000;
        error_cnt++;
        summarize();
    end
    initial begin
        doReset(1'b1);
        testSpi();
        testI2c();
        summarize();
    end
endmodule // tb_top
